// file: rtl/relay_regs_map.vh
`ifndef RELAY_REGS_MAP_VH
`define RELAY_REGS_MAP_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_STATUS      8'h00
`define ADDR_ADDRESS     8'h01
`define ADDR_RATE        8'h02
`define ADDR_TRAFFIC     8'h03
`define ADDR_PASSWORD    8'h04
`define ADDR_BANK        8'h05
`define ADDR_CBF_TIME    8'h06
`define ADDR_TEST        8'h07
`define ADDR_IRQ_STAT    8'h08
`define ADDR_IRQ_CLR     8'h09
`define ADDR_IRQ_EN      8'h0A
`define ADDR_PW_CHECK    8'h0B
`define ADDR_LINK_WRITE  8'h0C
// record stacks: base + 8*record + entry
`define ADDR_REC_BASE    8'h40
// ----------------------------------------
// field values and reset values
// ----------------------------------------
`define WEIGHT_BLOCK1    4'h1
`define WEIGHT_BLOCK2    4'h2
`define WEIGHT_RRESET    4'h4
`define RATE_4K8         1'b0
`define RATE_9K6         1'b1
`define RATE_RESET       1'b1
`define BANK_MAIN        1'b0
`define BANK_RESET       1'b0
// operate time in units of 0.1 s
`define CBF_TIME_MIN     4'h1
`define CBF_TIME_MAX     4'hA
`define CBF_TIME_RESET   4'h2
`define STACK_DEPTH      5
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ           50000000
`define TEST_STEP_MS     1000
`define TRAFFIC_TICK_MS  10
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_TRIP         0
`define IRQ_PW_REJECT    1
`define IRQ_TEST_DONE    2
`endif

// file: rtl/trip_stack.v
`timescale 1ns/1ps
// ----------------------------------------
// five deep trip value stack
// ----------------------------------------
module trip_stack #(
    parameter W     = 16,
    parameter DEPTH = 5
) (
    // clock and reset
    input  wire              clk,
    input  wire              rst,
    input  wire              ce,
    // control
    input  wire              clear,
    input  wire              push,
    input  wire [W-1:0]      din,
    input  wire [2:0]        sel,
    // read
    output reg  [W-1:0]      dout
);
    reg [W-1:0] mem_q [0:DEPTH-1];
    integer i;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= {W{1'b0}};
        end else if (ce) begin
            if (clear) begin
                for (i = 0; i < DEPTH; i = i + 1)
                    mem_q[i] <= {W{1'b0}};
            end else if (push) begin
                // entry 0 is newest; the oldest falls off the top
                mem_q[0] <= din;
                for (i = 1; i < DEPTH; i = i + 1)
                    mem_q[i] <= mem_q[i-1];
            end
        end
    end

    always @* begin
        if (sel < DEPTH)
            dout = mem_q[sel];
        else
            dout = {W{1'b0}};
    end
endmodule // trip_stack

// file: rtl/relay_record_status_regs.v
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "relay_regs_map.vh"
// Summary of operation
// (RULE1) each trip pushes phase angles of L1 and L3 into their record stacks
// (RULE2) stacks hold five entries; newest at entry 0, sixth trip drops oldest
// (RULE3) status digit sums weights 1, 2 and 4 of active inputs
// (RULE4) test mode from status register steps start and trip outputs one by one
// (RULE5) module address register identifies the module on the serial link
// (RULE6) link rate selectable 4.8 or 9.6 kBd, 9.6 kBd after initialisation
// (RULE7) traffic counter zero while link operates, else rolls 0 to 255
// (RULE8) link setting writes refused until correct password supplied
// (RULE9) bank selector 0 main, 1 second settings, default 0
// (RULE10) breaker failure operate time 0.1 to 1.0 s, default 0.2 s
// (RULE11) reset and program buttons together clear all records to zero
// (RULE12) loss of auxiliary power clears all records
// (RULE13) address, rate and password survive supply failure
// (RULE14) status digit follows the inputs continuously
module relay_record_status_regs #(
    parameter AW           = 8,
    parameter VW           = 16,
    parameter TEST_STEP_CY = (`CLK_HZ / 1000) * `TEST_STEP_MS,
    parameter TICK_CY      = (`CLK_HZ / 1000) * `TRAFFIC_TICK_MS,
    parameter NUM_OUTS     = 4
) (
    // clock and reset
    input  wire              clk,
    input  wire              rst,
    input  wire              ce,
    input  wire              aux_power_lost,
    // register port
    input  wire [AW-1:0]     addr,
    input  wire [15:0]       wdata,
    input  wire              wr,
    input  wire              rd,
    output reg  [15:0]       rdata,
    // inputs
    input  wire              block_input_one,
    input  wire              block_input_two,
    input  wire              remote_reset_input,
    input  wire              button_reset,
    input  wire              button_program,
    input  wire              trip_event,
    input  wire [VW-1:0]     angle_l1,
    input  wire [VW-1:0]     angle_l3,
    input  wire              link_operating,
    // non-volatile image loaded at power up
    input  wire              nv_load,
    input  wire [7:0]        nv_address,
    input  wire              nv_rate,
    input  wire [15:0]       nv_password,
    // outputs
    output reg  [7:0]        module_address,
    output reg               link_rate,
    output reg               setting_bank,
    output reg  [3:0]        cbf_time,
    output reg               nv_store,
    output reg  [NUM_OUTS-1:0] test_outputs,
    output reg               test_active,
    output reg               irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_STEP = 1'b1;

    reg  [3:0]  status_q;
    reg  [7:0]  traffic_q;
    reg  [31:0] tick_q;
    reg  [15:0] password_q;
    reg         unlocked_q;
    reg         state_q;
    reg  [31:0] step_q;
    reg  [2:0]  out_idx_q;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_en_q;
    reg  [2:0]  irq_set;
    wire        rec_clear;
    wire [VW-1:0] rec1_out;
    wire [VW-1:0] rec3_out;
    wire        link_wr;
    reg  [15:0] rd_d;
    wire        test_wr;
    wire        test_abort;
    wire        step_done;
    wire        last_out;

    // records clear on the button pair or whenever auxiliary power drops
    assign rec_clear  = (button_reset & button_program) | aux_power_lost; // RULE11 RULE12
    assign link_wr    = wr && (addr == `ADDR_LINK_WRITE);
    assign test_wr    = wr && (addr == `ADDR_TEST);
    // an abort in the last step wins, so it must not raise the done flag
    assign test_abort = test_wr && !wdata[0];
    assign step_done  = (step_q >= TEST_STEP_CY - 1);
    assign last_out   = (out_idx_q == NUM_OUTS - 1);

    // ----------------------------------------
    // record stacks
    // ----------------------------------------
    trip_stack #(.W(VW), .DEPTH(`STACK_DEPTH)) u_rec_l1 (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .clear (rec_clear),
        .push  (trip_event), // RULE1 RULE2
        .din   (angle_l1),
        .sel   (addr[2:0]),
        .dout  (rec1_out)
    );

    trip_stack #(.W(VW), .DEPTH(`STACK_DEPTH)) u_rec_l3 (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .clear (rec_clear),
        .push  (trip_event), // RULE1 RULE2
        .din   (angle_l3),
        .sel   (addr[2:0]),
        .dout  (rec3_out)
    );

    // ----------------------------------------
    // status digit and traffic counter
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q  <= 4'h0;
            traffic_q <= 8'h00;
            tick_q    <= 32'h0;
        end else if (ce) begin
            // registered: the digit lags the inputs by one cycle
            status_q <= (block_input_one    ? `WEIGHT_BLOCK1 : 4'h0)
                      + (block_input_two    ? `WEIGHT_BLOCK2 : 4'h0)
                      + (remote_reset_input ? `WEIGHT_RRESET : 4'h0); // RULE3 RULE14
            // a running link pins the counter at zero; otherwise it rolls over
            if (link_operating) begin
                traffic_q <= 8'h00; // RULE7
                tick_q    <= 32'h0;
            end else if (tick_q >= TICK_CY - 1) begin
                tick_q    <= 32'h0;
                traffic_q <= traffic_q + 8'h01; // RULE7
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // settings, password and interrupts
    // ----------------------------------------
    always @* begin
        irq_set = 3'h0;
        irq_set[`IRQ_TRIP] = trip_event;
        // a link write lost to an image load is neither taken nor refused
        irq_set[`IRQ_PW_REJECT] = link_wr && !nv_load && !unlocked_q; // RULE8
        irq_set[`IRQ_TEST_DONE] = (state_q == ST_STEP) && step_done && last_out
                                  && !test_abort;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            module_address <= 8'h00;
            link_rate      <= `RATE_RESET;
            password_q     <= 16'h0000;
            unlocked_q     <= 1'b0;
            setting_bank   <= `BANK_RESET;
            cbf_time       <= `CBF_TIME_RESET;
            nv_store       <= 1'b0;
            irq_stat_q     <= 3'h0;
            irq_en_q       <= 3'h0;
            irq            <= 1'b0;
        end else if (ce) begin
            // store is a one-cycle request to save the non-volatile image
            nv_store <= 1'b0;
            if (nv_load) begin
                module_address <= nv_address; // RULE13
                link_rate      <= nv_rate;
                password_q     <= nv_password;
                unlocked_q     <= 1'b0;
            end else if (wr) begin
                case (addr)
                    `ADDR_ADDRESS: begin
                        module_address <= wdata[7:0]; // RULE5
                        nv_store       <= 1'b1; // RULE13
                    end
                    `ADDR_RATE: begin
                        link_rate <= wdata[0]; // RULE6
                        nv_store  <= 1'b1;
                    end
                    `ADDR_PASSWORD: begin
                        password_q <= wdata;
                        nv_store   <= 1'b1;
                        // a new password needs a fresh check before link writes
                        unlocked_q <= 1'b0; // RULE8
                    end
                    `ADDR_BANK:     setting_bank <= wdata[0]; // RULE9
                    `ADDR_CBF_TIME: begin
                        if (wdata[3:0] >= `CBF_TIME_MIN && wdata[3:0] <= `CBF_TIME_MAX)
                            cbf_time <= wdata[3:0]; // RULE10
                    end
                    `ADDR_PW_CHECK: unlocked_q <= (wdata == password_q); // RULE8
                    `ADDR_LINK_WRITE: begin
                        // remote setting write, accepted only when unlocked
                        if (unlocked_q) begin
                            case (wdata[15:12])
                                4'h5: setting_bank <= wdata[0]; // RULE8 RULE9
                                4'h6: begin
                                    if (wdata[3:0] >= `CBF_TIME_MIN &&
                                        wdata[3:0] <= `CBF_TIME_MAX)
                                        cbf_time <= wdata[3:0]; // RULE8
                                end
                                default: ;
                            endcase
                        end
                    end
                    `ADDR_IRQ_EN:   irq_en_q <= wdata[2:0];
                    default: ;
                endcase
            end
            // set wins over clear
            if (wr && addr == `ADDR_IRQ_CLR)
                irq_stat_q <= (irq_stat_q & ~wdata[2:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ----------------------------------------
    // test mode sequencer
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= ST_IDLE;
            step_q       <= 32'h0;
            out_idx_q    <= 3'h0;
            test_outputs <= {NUM_OUTS{1'b0}};
            test_active  <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ST_IDLE: begin
                    test_outputs <= {NUM_OUTS{1'b0}};
                    test_active  <= 1'b0;
                    if (wr && addr == `ADDR_TEST && wdata[0]) begin
                        state_q      <= ST_STEP; // RULE4
                        step_q       <= 32'h0;
                        out_idx_q    <= 3'h0;
                        test_active  <= 1'b1;
                        test_outputs <= {{(NUM_OUTS-1){1'b0}}, 1'b1};
                    end
                end
                // each output stands for TEST_STEP_CY cycles in turn, the last one for TEST_STEP_CY + 1
                ST_STEP: begin
                    if (wr && addr == `ADDR_TEST && !wdata[0]) begin
                        state_q <= ST_IDLE;
                    end else if (step_q >= TEST_STEP_CY - 1) begin
                        step_q <= 32'h0;
                        if (out_idx_q == NUM_OUTS - 1) begin
                            state_q <= ST_IDLE;
                        end else begin
                            out_idx_q    <= out_idx_q + 3'h1;
                            test_outputs <= test_outputs << 1; // RULE4
                        end
                    end else begin
                        step_q <= step_q + 32'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always @* begin
        rd_d = 16'h0000;
        case (addr)
            `ADDR_STATUS:   rd_d = {12'h000, status_q};
            `ADDR_ADDRESS:  rd_d = {8'h00, module_address};
            `ADDR_RATE:     rd_d = {15'h0000, link_rate};
            `ADDR_TRAFFIC:  rd_d = {8'h00, traffic_q};
            `ADDR_BANK:     rd_d = {15'h0000, setting_bank};
            `ADDR_CBF_TIME: rd_d = {12'h000, cbf_time};
            `ADDR_TEST:     rd_d = {15'h0000, test_active};
            `ADDR_IRQ_STAT: rd_d = {13'h0000, irq_stat_q};
            `ADDR_IRQ_EN:   rd_d = {13'h0000, irq_en_q};
            `ADDR_PW_CHECK: rd_d = {15'h0000, unlocked_q};
            default: begin
                // records: L1 stack at 0x40 to 0x47, L3 stack at 0x48 to 0x4F
                if (addr[7:4] == 4'h4 && addr[3] == 1'b0)
                    rd_d = rec1_out;
                else if (addr[7:4] == 4'h4)
                    rd_d = rec3_out;
            end
        endcase
    end

    // read data stand from the cycle after the strobe until the next read
    always @(posedge clk or posedge rst) begin
        if (rst)
            rdata <= 16'h0000;
        else if (ce && rd)
            rdata <= rd_d;
    end
endmodule // relay_record_status_regs

// file: test/relay_regs_chk.sv
`timescale 1ns/1ps
`include "relay_regs_map.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module relay_regs_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        nv_load,
    input wire logic [15:0] rdata,
    input wire logic [7:0]  module_address,
    input wire logic        link_rate,
    input wire logic        setting_bank,
    input wire logic [3:0]  cbf_time,
    input wire logic        nv_store,
    input wire logic [3:0]  test_outputs,
    input wire logic        test_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_rate_cause: assert property ($changed(link_rate) |->
        $past(nv_load || (wr && addr == `ADDR_RATE))) else $error("rate changed without cause");
    a_addr_cause: assert property ($changed(module_address) |->
        $past(nv_load || (wr && addr == `ADDR_ADDRESS))) else $error("address changed alone");
    a_bank_cause: assert property ($changed(setting_bank) |->
        $past(wr && (addr == `ADDR_LINK_WRITE || addr == `ADDR_BANK))) else $error("bank changed");
    a_cbf_range: assert property (cbf_time >= `CBF_TIME_MIN && cbf_time <= `CBF_TIME_MAX)
        else $error("operate time out of range");
    a_nv_store_after: assert property (ce && !nv_load && wr && (addr == `ADDR_ADDRESS
        || addr == `ADDR_RATE || addr == `ADDR_PASSWORD) |=> nv_store)
        else $error("no store pulse");
    a_store_cause: assert property (nv_store && $past(ce) |-> $past(wr))
        else $error("stray store pulse");
    a_test_onehot: assert property ($onehot0(test_outputs)) else $error("outputs not one by one");
    a_test_gated: assert property (|test_outputs |-> test_active) else $error("output outside test");
    a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata)) else $error("read data moved");
endmodule // relay_regs_chk
bind relay_record_status_regs relay_regs_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wr(wr), .rd(rd), .nv_load(nv_load), .rdata(rdata), .module_address(module_address),
    .link_rate(link_rate), .setting_bank(setting_bank), .cbf_time(cbf_time), .nv_store(nv_store),
    .test_outputs(test_outputs), .test_active(test_active));

// file: test/link_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// control data communicator: link comes up two cycles after request
// ----------------------------------------
module link_partner (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic want,
    output logic      link_operating
);
    logic [1:0] up_q;
    always @(posedge clk or posedge rst) begin
        if (rst) up_q <= 2'h0;
        else up_q <= {up_q[0], want};
    end
    assign link_operating = up_q[1];
endmodule // link_partner

// file: test/relay_record_status_regs_tb.sv
`timescale 1ns/1ps
`include "relay_regs_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module relay_record_status_regs_tb;
    logic clk, rst, ce, aux_power_lost, wr, rd, b1, b2, rr, br, bp, trip_event, want, link_operating;
    logic nv_load, nv_rate, link_rate, setting_bank, nv_store, test_active, irq;
    logic [7:0]  addr, nv_address, module_address;
    logic [15:0] wdata, rdata, a1, a3, nv_password, lfsr_q;
    logic [3:0]  cbf_time, test_outputs;
    int bad_count, n_checks, k, v;
    int q1[$], q3[$];
    relay_record_status_regs #(.TEST_STEP_CY(8), .TICK_CY(4)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .aux_power_lost(aux_power_lost), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .block_input_one(b1), .block_input_two(b2), .remote_reset_input(rr),
        .button_reset(br), .button_program(bp), .trip_event(trip_event), .angle_l1(a1),
        .angle_l3(a3), .link_operating(link_operating), .nv_load(nv_load),
        .nv_address(nv_address), .nv_rate(nv_rate), .nv_password(nv_password),
        .module_address(module_address), .link_rate(link_rate), .setting_bank(setting_bank),
        .cbf_time(cbf_time), .nv_store(nv_store), .test_outputs(test_outputs),
        .test_active(test_active), .irq(irq));
    link_partner u_link (.clk(clk), .rst(rst), .want(want), .link_operating(link_operating));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask
    task trip;
        @(posedge clk);
        lfsr_q = lfsr(lfsr_q);
        a1 <= lfsr_q;
        a3 <= ~lfsr_q;
        trip_event <= 1'b1;
        q1.push_front(lfsr_q);
        q3.push_front(~lfsr_q);
        if (q1.size() > `STACK_DEPTH) begin
            void'(q1.pop_back());
            void'(q3.pop_back());
        end
        @(posedge clk);
        trip_event <= 1'b0;
    endtask
    task check_stacks;
        for (int n = 0; n < 6; n++) begin
            rreg(8'(`ADDR_REC_BASE + n));
            `CHK(rdata, n < q1.size() ? 16'(q1[n]) : 16'h0000)
            rreg(8'(`ADDR_REC_BASE + 8 + n));
            `CHK(rdata, n < q3.size() ? 16'(q3[n]) : 16'h0000)
        end
    endtask
    task close_out;
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        close_out;
    end
    initial begin
        {ce, rst} = 2'b11;
        {aux_power_lost, wr, rd, b1, b2, rr, br, bp, trip_event, want, nv_load, nv_rate} = 0;
        {addr, nv_address, wdata, a1, a3} = 0;
        nv_password = 16'h1234;
        lfsr_q = 16'h9AD8;
        tick(4);
        rst <= 1'b0;
        tick(1);
        `CHK(link_rate, `RATE_RESET)
        `CHK(setting_bank, `BANK_MAIN)
        `CHK(cbf_time, `CBF_TIME_RESET)
        for (k = 0; k < 8; k++) begin
            {rr, b2, b1} <= 3'(k);
            tick(2);
            rreg(`ADDR_STATUS);
            `CHK(rdata[3:0], 4'(k))
        end
        repeat (6) trip;
        check_stacks;
        br <= 1'b1;
        tick(2);
        check_stacks;
        bp <= 1'b1;
        tick(1);
        {br, bp} <= 2'b00;
        q1.delete();
        q3.delete();
        check_stacks;
        repeat (2) trip;
        aux_power_lost <= 1'b1;
        tick(1);
        aux_power_lost <= 1'b0;
        q1.delete();
        q3.delete();
        check_stacks;
        ce <= 1'b0;
        wreg(`ADDR_ADDRESS, 16'h00FF);
        ce <= 1'b1;
        tick(1);
        `CHK(module_address, 8'h00)
        wreg(`ADDR_ADDRESS, 16'h005A);
        tick(1);
        `CHK(module_address, 8'h5A)
        wreg(`ADDR_RATE, 16'h0000);
        tick(1);
        `CHK(link_rate, `RATE_4K8)
        {nv_address, nv_rate, nv_load} <= {8'hA5, 1'b1, 1'b1};
        tick(1);
        nv_load <= 1'b0;
        tick(1);
        `CHK({module_address, link_rate}, {8'hA5, `RATE_9K6})
        wreg(`ADDR_IRQ_EN, 16'h0002);
        wreg(`ADDR_LINK_WRITE, 16'h5001);
        tick(2);
        `CHK(setting_bank, `BANK_MAIN)
        `CHK(irq, 1'b1)
        wreg(`ADDR_IRQ_CLR, 16'h0002);
        tick(2);
        `CHK(irq, 1'b0)
        wreg(`ADDR_PW_CHECK, 16'h1234);
        wreg(`ADDR_LINK_WRITE, 16'h5001);
        tick(1);
        `CHK(setting_bank, 1'b1)
        wreg(`ADDR_LINK_WRITE, 16'h6007);
        wreg(`ADDR_LINK_WRITE, 16'h600B);
        tick(1);
        `CHK(cbf_time, 4'h7)
        rreg(8'h30);
        `CHK(rdata, 16'h0000)
        want <= 1'b1;
        tick(8);
        rreg(`ADDR_TRAFFIC);
        `CHK(rdata, 16'h0000)
        want <= 1'b0;
        tick(20);
        rreg(`ADDR_TRAFFIC);
        v = rdata;
        tick(8);
        rreg(`ADDR_TRAFFIC);
        `CHK(rdata === 16'(v), 1'b0)
        wreg(`ADDR_TEST, 16'h0001);
        for (k = 0; k < 4; k++) begin
            for (v = 0; v < 40 && test_outputs !== 4'(1 << k); v++) @(posedge clk);
            `CHK(test_outputs, 4'(1 << k))
        end
        for (v = 0; v < 40 && test_active !== 1'b0; v++) @(posedge clk);
        `CHK(test_active, 1'b0)
        rreg(`ADDR_IRQ_STAT);
        `CHK(rdata[2], 1'b1)
        wreg(`ADDR_IRQ_CLR, 16'h0004);
        wreg(`ADDR_TEST, 16'h0001);
        wreg(`ADDR_TEST, 16'h0000);
        tick(2);
        `CHK(test_active, 1'b0)
        `CHK(test_outputs, 4'h0)
        rreg(`ADDR_IRQ_STAT);
        `CHK(rdata[2], 1'b0)
        close_out;
    end
endmodule // relay_record_status_regs_tb
